/* rtl/acb_unit.sv */
// Behaviour
// (RULE_01) Single xor: low half with one word
// (RULE_02) Xor of either width updates zero flag
// (RULE_03) Double xor: full accumulator, pair or immediate; the code has no immediate and always uses the operand pair
// (RULE_04) Double logical sets negative from top bit
// (RULE_05) Flags hold until next affecting operation
// (RULE_06) Single compare: low half, flags only
// (RULE_07) Compare sets exactly one of less/equal/greater
// (RULE_08) Double compare: full accumulator vs operand
// (RULE_09) Single BCD add stores sum in accumulator
// (RULE_10) Double BCD add over full accumulator
// (RULE_11) Single add carry sets carry16 flag
// (RULE_12) Double add carry sets carry32 flag
// (RULE_13) Non-decimal nibble sets invalid BCD flag
// (RULE_14) BCD add updates zero flag
// (RULE_15) BCD add updates negative flag
// (RULE_16) Unlisted flags stay unchanged
// (RULE_17) Compare leaves accumulator unchanged
// (RULE_18) One digit per nibble, low digit lowest
//
// The implementer's own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module acb_unit (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic [1:0] hresp,
  output acb_pkg::acb_flags_t flags
);

  // ------------------------------------------------------------
  // Decimal helpers
  // ------------------------------------------------------------
  // Packed BCD add, returns {carry out of digit 3, carry out of digit 7, sum}
  function automatic logic [33:0] bcd_add(input logic [31:0] a, input logic [31:0] b);
    logic [4:0] s;
    logic c;
    logic c4;
    logic [31:0] r;
    c = 1'b0;
    c4 = 1'b0;
    r = acb_pkg::ACB_WORD_RST;
    for (int i = 0; i < acb_pkg::ACB_DIGITS; i++) begin // RULE_18
      s = {1'b0, a[i*acb_pkg::ACB_DIGIT_W +: acb_pkg::ACB_DIGIT_W]}
        + {1'b0, b[i*acb_pkg::ACB_DIGIT_W +: acb_pkg::ACB_DIGIT_W]} + {4'h0, c};
      if (s > acb_pkg::ACB_DIGIT_MAX) begin
        s = s + acb_pkg::ACB_DIGIT_ADJ;
        c = 1'b1;
      end else begin
        c = 1'b0;
      end
      r[i*acb_pkg::ACB_DIGIT_W +: acb_pkg::ACB_DIGIT_W] = s[3:0];
      if (i == acb_pkg::ACB_HALF_DIGITS - 1) begin
        c4 = c;
      end
    end
    return {c4, c, r};
  endfunction

  // True when any nibble of the value is not a decimal digit
  function automatic logic bcd_bad(input logic [31:0] v);
    logic bad;
    bad = 1'b0;
    for (int i = 0; i < acb_pkg::ACB_DIGITS; i++) begin
      if ({1'b0, v[i*acb_pkg::ACB_DIGIT_W +: acb_pkg::ACB_DIGIT_W]} > acb_pkg::ACB_DIGIT_MAX) begin
        bad = 1'b1;
      end
    end
    return bad;
  endfunction

  // ------------------------------------------------------------
  // Bus slave state
  // ------------------------------------------------------------
  logic dp_valid_q;                       // Data phase pending
  logic dp_write_q;                       // Pending phase is a write
  logic [7:0] dp_addr_q;                  // Pending phase address
  logic [31:0] hrdata_q;                  // Read data for the data phase
  logic hreadyout_q;                      // Always ready, zero wait
  logic [31:0] acc_q;                     // Accumulator
  logic [31:0] acc_d;
  logic [31:0] opnd_q;                    // Operand word pair
  logic [31:0] opnd_d;
  logic [5:0] last_op_q;                  // Last code written
  acb_pkg::acb_flags_t flags_q;
  acb_pkg::acb_flags_t flags_d;

  // Address phase accepted this cycle
  wire logic ap_take = hsel && hready && (htrans == acb_pkg::ACB_HTRANS_NONSEQ);
  wire logic [7:0] ap_addr = haddr[acb_pkg::ACB_ADDR_W-1:0];

  // Write strobes during the data phase
  wire logic wr_dp = dp_valid_q && dp_write_q;
  wire logic wr_acc = wr_dp && (dp_addr_q == acb_pkg::ACB_ACC_ADDR);
  wire logic wr_lo = wr_dp && (dp_addr_q == acb_pkg::ACB_OPND_LO_ADDR);
  wire logic wr_hi = wr_dp && (dp_addr_q == acb_pkg::ACB_OPND_HI_ADDR);
  wire logic wr_cmd = wr_dp && (dp_addr_q == acb_pkg::ACB_CMD_ADDR);
  wire logic [5:0] cmd_code = hwdata[acb_pkg::ACB_OP_W-1:0];

  // Read mux on the address phase, unmapped reads return zero
  wire logic [31:0] rd_mux =
    (ap_addr == acb_pkg::ACB_ACC_ADDR) ? acc_q :
    (ap_addr == acb_pkg::ACB_OPND_LO_ADDR) ? {acb_pkg::ACB_HALF_ZERO, opnd_q[15:0]} :
    (ap_addr == acb_pkg::ACB_OPND_HI_ADDR) ? {acb_pkg::ACB_HALF_ZERO, opnd_q[31:16]} :
    (ap_addr == acb_pkg::ACB_CMD_ADDR) ? {26'h000_0000, last_op_q} :
    (ap_addr == acb_pkg::ACB_FLAGS_ADDR) ? {24'h00_0000, flags_q} :
    acb_pkg::ACB_WORD_RST;

  // ------------------------------------------------------------
  // Datapath
  // ------------------------------------------------------------
  wire logic [15:0] acc_lo = acc_q[15:0];
  wire logic [15:0] opnd_lo = opnd_q[15:0];
  wire logic [31:0] xor16 = {acb_pkg::ACB_HALF_ZERO, acc_lo ^ opnd_lo}; // RULE_01
  wire logic [31:0] xor32 = acc_q ^ opnd_q; // RULE_03
  wire logic [33:0] add16 = bcd_add({acb_pkg::ACB_HALF_ZERO, acc_lo},
                                    {acb_pkg::ACB_HALF_ZERO, opnd_lo}); // RULE_09
  wire logic [33:0] add32 = bcd_add(acc_q, opnd_q); // RULE_10
  wire logic bad16 = bcd_bad({acb_pkg::ACB_HALF_ZERO, acc_lo})
                   || bcd_bad({acb_pkg::ACB_HALF_ZERO, opnd_lo});
  wire logic bad32 = bcd_bad(acc_q) || bcd_bad(opnd_q);
  // Single add keeps the upper half clear; its decimal carry only reaches the flag
  wire logic [31:0] sum16 = {acb_pkg::ACB_HALF_ZERO, add16[15:0]}; // RULE_09
  // Flags that compares must leave alone
  wire logic [4:0] keep_flags = {flags_q.invalid_bcd_flag, flags_q.negative_result_flag,
    flags_q.carry32_flag, flags_q.carry16_flag, flags_q.zero_result_flag};

  // Next accumulator and flags; unlisted flags keep their value
  always_comb begin
    acc_d = acc_q;
    flags_d = flags_q; // RULE_16 RULE_05
    if (wr_acc) begin
      acc_d = hwdata;
    end
    if (wr_cmd) begin
      case (cmd_code)
        acb_pkg::ACB_OP_XOR16: begin
          acc_d = xor16;
          flags_d.zero_result_flag = (xor16 == acb_pkg::ACB_WORD_RST); // RULE_02
        end
        acb_pkg::ACB_OP_XOR32: begin
          acc_d = xor32;
          flags_d.zero_result_flag = (xor32 == acb_pkg::ACB_WORD_RST); // RULE_02
          flags_d.negative_result_flag = xor32[acb_pkg::ACB_DATA_W-1]; // RULE_04
        end
        acb_pkg::ACB_OP_CMP16: begin // RULE_06 RULE_17
          flags_d.less_than_flag = (acc_lo < opnd_lo); // RULE_07
          flags_d.equal_flag = (acc_lo == opnd_lo);
          flags_d.greater_than_flag = (acc_lo > opnd_lo);
        end
        acb_pkg::ACB_OP_CMP32: begin // RULE_08 RULE_17
          flags_d.less_than_flag = (acc_q < opnd_q); // RULE_07
          flags_d.equal_flag = (acc_q == opnd_q);
          flags_d.greater_than_flag = (acc_q > opnd_q);
        end
        acb_pkg::ACB_OP_ADD16: begin
          acc_d = sum16;
          flags_d.carry16_flag = add16[33]; // RULE_11
          flags_d.invalid_bcd_flag = bad16; // RULE_13
          flags_d.zero_result_flag = (sum16 == acb_pkg::ACB_WORD_RST); // RULE_14
          flags_d.negative_result_flag = sum16[acb_pkg::ACB_DATA_W-1]; // RULE_15
        end
        acb_pkg::ACB_OP_ADD32: begin
          acc_d = add32[31:0];
          flags_d.carry32_flag = add32[32]; // RULE_12
          flags_d.invalid_bcd_flag = bad32; // RULE_13
          flags_d.zero_result_flag = (add32[31:0] == acb_pkg::ACB_WORD_RST); // RULE_14
          flags_d.negative_result_flag = add32[acb_pkg::ACB_DATA_W-1]; // RULE_15
        end
        default: begin
          acc_d = acc_q;
        end
      endcase
    end
  end

  // Operand words, first word in the low half
  always_comb begin
    opnd_d = opnd_q;
    if (wr_lo) begin
      opnd_d[15:0] = hwdata[15:0];
    end
    if (wr_hi) begin
      opnd_d[31:16] = hwdata[15:0];
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  // Bus phase tracking and read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_q <= 1'b0;
      dp_write_q <= 1'b0;
      dp_addr_q <= 8'h00;
      hrdata_q <= acb_pkg::ACB_WORD_RST;
      hreadyout_q <= 1'b1;
    end else begin
      dp_valid_q <= ap_take;
      dp_write_q <= hwrite;
      dp_addr_q <= ap_addr;
      hrdata_q <= (ap_take && !hwrite) ? rd_mux : acb_pkg::ACB_WORD_RST;
      hreadyout_q <= 1'b1;
    end
  end

  // Architectural state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q <= acb_pkg::ACB_WORD_RST;
      opnd_q <= acb_pkg::ACB_WORD_RST;
      last_op_q <= 6'h00;
      flags_q <= acb_pkg::ACB_FLAGS_RST;
    end else begin
      acc_q <= acc_d;
      opnd_q <= opnd_d;
      last_op_q <= wr_cmd ? cmd_code : last_op_q;
      flags_q <= flags_d;
    end
  end

  // Outputs straight from flip-flops; hresp tied to OKAY
  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = acb_pkg::ACB_HRESP_OKAY;
  assign flags = flags_q;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_run(logic [5:0] code);
    wr_cmd && (cmd_code == code);
  endsequence

  a_xor16_result: assert property (s_run(acb_pkg::ACB_OP_XOR16) |=> // RULE_01
    acc_q == {acb_pkg::ACB_HALF_ZERO, $past(acc_q[15:0] ^ opnd_q[15:0])})
    else $error("single xor result wrong");
  a_xor_zero_flag: assert property ((s_run(acb_pkg::ACB_OP_XOR16) or // RULE_02
    s_run(acb_pkg::ACB_OP_XOR32)) |=> flags_q.zero_result_flag == (acc_q == 32'h0000_0000))
    else $error("xor zero flag wrong");
  a_xor32_negative: assert property (s_run(acb_pkg::ACB_OP_XOR32) |=> // RULE_04 RULE_03
    acc_q == $past(acc_q ^ opnd_q) && flags_q.negative_result_flag == acc_q[31])
    else $error("double xor result or negative flag wrong");
  a_flags_hold: assert property (!wr_cmd |=> flags_q == $past(flags_q)) // RULE_05
    else $error("flags changed without an operation");
  a_cmp_onehot: assert property ((s_run(acb_pkg::ACB_OP_CMP16) or // RULE_07
    s_run(acb_pkg::ACB_OP_CMP32)) |=> $onehot({flags_q.less_than_flag,
    flags_q.equal_flag, flags_q.greater_than_flag}) && acc_q == $past(acc_q))
    else $error("compare flags not exclusive or accumulator moved");
  a_cmp16_less: assert property (s_run(acb_pkg::ACB_OP_CMP16) |=> // RULE_06
    flags_q.less_than_flag == ($past(acc_q[15:0]) < $past(opnd_q[15:0])))
    else $error("single compare less flag wrong");
  a_add16_carry: assert property (s_run(acb_pkg::ACB_OP_ADD16) ##0 // RULE_11
    (acc_lo == 16'h9999 && opnd_lo == 16'h0001) |=> flags_q.carry16_flag &&
    acc_q == 32'h0000_0000 && flags_q.zero_result_flag)
    else $error("single add carry wrong");
  a_add32_carry: assert property (s_run(acb_pkg::ACB_OP_ADD32) |=> // RULE_12
    flags_q.carry32_flag == $past(add32[32]) &&
    flags_q.carry16_flag == $past(flags_q.carry16_flag))
    else $error("double add carry wrong");
  a_bcd_invalid: assert property (s_run(acb_pkg::ACB_OP_ADD32) ##0 // RULE_13
    (opnd_q[3:0] > 4'hA - 4'h1) |=> flags_q.invalid_bcd_flag)
    else $error("invalid digit not flagged");
  a_zero_wait: assert property (ap_take && !hwrite |=> hreadyout && hrdata == $past(rd_mux))
    else $error("read data not returned in one cycle");

  // Either width of compare
  sequence s_cmp_any;
    s_run(acb_pkg::ACB_OP_CMP16) or s_run(acb_pkg::ACB_OP_CMP32);
  endsequence

  // Single add with a bad digit in the third nibble of the low half
  sequence s_add16_bad;
    s_run(acb_pkg::ACB_OP_ADD16) ##0 (acc_lo[11:8] > 4'h9);
  endsequence

  a_cmp32_order: assert property (s_run(acb_pkg::ACB_OP_CMP32) |=> // RULE_08
    flags_q.less_than_flag == ($past(acc_q) < $past(opnd_q)) &&
    flags_q.greater_than_flag == ($past(acc_q) > $past(opnd_q)))
    else $error("double compare order flags wrong");
  a_cmp_keeps: assert property (s_cmp_any |=> keep_flags == $past(keep_flags)) // RULE_16
    else $error("compare touched a flag it does not own");
  a_add16_upper: assert property (s_run(acb_pkg::ACB_OP_ADD16) |=> // RULE_09
    acc_q[31:16] == 16'h0000 && !flags_q.negative_result_flag &&
    flags_q.carry32_flag == $past(flags_q.carry32_flag))
    else $error("single add touched upper half or carry32");
  a_add16_invalid: assert property (s_add16_bad |=> flags_q.invalid_bcd_flag) // RULE_13
    else $error("bad digit in single add not flagged");
  a_add32_digits: assert property (s_run(acb_pkg::ACB_OP_ADD32) ##0 // RULE_10
    (acc_q == 32'h5000_0000 && opnd_q == 32'h4000_0000) |=>
    acc_q == 32'h9000_0000 && flags_q.negative_result_flag)
    else $error("double add digits or negative flag wrong");
  a_add_zero_flag: assert property ((s_run(acb_pkg::ACB_OP_ADD16) or // RULE_14
    s_run(acb_pkg::ACB_OP_ADD32)) |=> flags_q.zero_result_flag == (acc_q == 32'h0000_0000))
    else $error("add zero flag wrong");
  a_add32_negative: assert property (s_run(acb_pkg::ACB_OP_ADD32) |=> // RULE_15
    flags_q.negative_result_flag == acc_q[31])
    else $error("double add negative flag wrong");
  a_acc_hold: assert property (!wr_cmd && !wr_acc |=> acc_q == $past(acc_q))
    else $error("accumulator moved without a write or operation");

endmodule

`default_nettype wire

/* rtl/acb_pkg.sv */
`default_nettype none

package acb_pkg;

  // ------------------------------------------------------------
  // Register map (byte addresses, one word each)
  // ------------------------------------------------------------
  localparam logic [7:0] ACB_ACC_ADDR = 8'h00;     // Accumulator, read/write
  localparam logic [7:0] ACB_OPND_LO_ADDR = 8'h04; // First operand word
  localparam logic [7:0] ACB_OPND_HI_ADDR = 8'h08; // Second operand word
  localparam logic [7:0] ACB_CMD_ADDR = 8'h0C;     // Operation code, write runs it
  localparam logic [7:0] ACB_FLAGS_ADDR = 8'h10;   // Status flags, read only
  localparam int ACB_ADDR_W = 8;                   // Decoded address bits

  // ------------------------------------------------------------
  // Widths and reset values
  // ------------------------------------------------------------
  localparam int ACB_DATA_W = 32;
  localparam int ACB_HALF_W = 16;
  localparam int ACB_DIGIT_W = 4;
  localparam int ACB_DIGITS = 8;
  localparam int ACB_HALF_DIGITS = 4;
  localparam logic [31:0] ACB_WORD_RST = 32'h0000_0000;
  localparam logic [15:0] ACB_HALF_ZERO = 16'h0000;
  localparam logic [4:0] ACB_DIGIT_MAX = 5'h09;    // Largest decimal digit
  localparam logic [4:0] ACB_DIGIT_ADJ = 5'h06;    // Decimal carry correction
  localparam logic [1:0] ACB_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] ACB_HRESP_OKAY = 2'h0;

  // ------------------------------------------------------------
  // Operation codes, one-hot
  // ------------------------------------------------------------
  typedef enum logic [5:0] {
    ACB_OP_XOR16 = 6'b000001, // single exclusive-or
    ACB_OP_XOR32 = 6'b000010, // double_exclusive_or_op
    ACB_OP_CMP16 = 6'b000100, // single_compare_op
    ACB_OP_CMP32 = 6'b001000, // double_compare_op
    ACB_OP_ADD16 = 6'b010000, // single BCD add
    ACB_OP_ADD32 = 6'b100000  // double_bcd_add_op
  } acb_op_t;
  localparam int ACB_OP_W = 6;

  // Discrete status flags, register bit order from bit 7 downward
  typedef struct packed {
    logic invalid_bcd_flag;     // Bit 7
    logic negative_result_flag; // Bit 6
    logic carry32_flag;         // Bit 5
    logic carry16_flag;         // Bit 4
    logic zero_result_flag;     // Bit 3
    logic greater_than_flag;    // Bit 2
    logic equal_flag;           // Bit 1
    logic less_than_flag;       // Bit 0
  } acb_flags_t;
  localparam int ACB_FLAGS_W = 8;
  localparam acb_flags_t ACB_FLAGS_RST = 8'h00;

endpackage

`default_nettype wire

/* verif/acb_seq_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Sequencer and data memory side: single AHB-Lite word transfers
// ------------------------------------------------------------
module acb_seq_model (
  input wire logic hclk,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic [1:0] hresp,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // Idle bus at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end

  // One transfer; call just after a rising edge
  task automatic bus_xfer(input logic we, input logic [31:0] addr, input logic [31:0] wdata,
                          output logic [31:0] rdata, output logic [1:0] resp);
    hsel <= 1'b1;
    htrans <= acb_pkg::ACB_HTRANS_NONSEQ;
    haddr <= addr;
    hwrite <= we;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    // Data phase: released address shows its inverse, not the old value
    hsel <= 1'b0;
    htrans <= 2'h0;
    haddr <= ~addr;
    hwdata <= we ? wdata : ~hwdata;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rdata = hrdata;
    resp = hresp;
    hwdata <= ~wdata;
  endtask
endmodule

`default_nettype wire

/* verif/test_accumulator_logic_compare_bcd_add.sv */
`timescale 1ns/1ps
`default_nettype none

module test_accumulator_logic_compare_bcd_add;
  // ------------------------------------------------------------
  // Signals and bench state
  // ------------------------------------------------------------
  logic hclk, hresetn, hsel, hwrite, hreadyout;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans, hresp;
  logic [2:0] hsize;
  acb_pkg::acb_flags_t flags, exp_f; // Seen and modelled flags
  logic [31:0] exp_acc; // Modelled accumulator
  int n_errors, cmp_count;

  // Clock, 8 ns period
  initial hclk = 1'b0;
  always #4 hclk = ~hclk;

  acb_unit dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .flags(flags));
  acb_seq_model seq_u (.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));

  // ------------------------------------------------------------
  // Compare, bus access and closing tasks
  // ------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic [1:0] s;
    seq_u.bus_xfer(1'b1, {24'h00_0000, a}, d, q, s);
    check("hresp", {30'h0000_0000, s}, 32'h0000_0000);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic [1:0] s;
    seq_u.bus_xfer(1'b0, {24'h00_0000, a}, 32'h0000_0000, d, s);
    check("hreadyout", {31'h0000_0000, hreadyout}, 32'h0000_0001);
    check("hresp", {30'h0000_0000, s}, 32'h0000_0000);
  endtask

  task automatic conclude();
    $display("Comparisons %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Reference model of one operation on exp_acc and exp_f
  // ------------------------------------------------------------
  task automatic model_op(input acb_pkg::acb_op_t op, input logic [31:0] b);
    int s, nd;
    logic c, inv, cmp;
    logic [31:0] a;
    a = exp_acc;
    c = 1'b0;
    inv = 1'b0;
    nd = (op == acb_pkg::ACB_OP_ADD16) ? 4 : 8;
    cmp = (op == acb_pkg::ACB_OP_CMP16) || (op == acb_pkg::ACB_OP_CMP32);
    if (op == acb_pkg::ACB_OP_XOR16) begin
      exp_acc = {16'h0000, a[15:0] ^ b[15:0]};
    end else if (op == acb_pkg::ACB_OP_XOR32) begin
      exp_acc = a ^ b;
    end else if (cmp) begin
      // Single compare looks at low halves only
      if (op == acb_pkg::ACB_OP_CMP16) begin
        a = {16'h0000, a[15:0]};
        b = {16'h0000, b[15:0]};
      end
      exp_f.less_than_flag = a < b;
      exp_f.equal_flag = a == b;
      exp_f.greater_than_flag = a > b;
    end else begin
      // Digit-serial decimal add, low digit first
      exp_acc = 32'h0000_0000;
      for (int i = 0; i < nd; i++) begin
        if (a[4*i+:4] > 4'h9 || b[4*i+:4] > 4'h9) inv = 1'b1;
        s = a[4*i+:4] + b[4*i+:4] + c;
        c = s > 9;
        if (c) s = s + 6;
        exp_acc[4*i+:4] = s[3:0];
      end
      exp_f.invalid_bcd_flag = inv;
      if (nd == 4) exp_f.carry16_flag = c;
      else exp_f.carry32_flag = c;
    end
    if (!cmp) exp_f.zero_result_flag = exp_acc == 32'h0000_0000;
    if (!cmp && op != acb_pkg::ACB_OP_XOR16) exp_f.negative_result_flag = exp_acc[31];
  endtask

  // Load accumulator and operand, run one code, check all results
  task automatic run(input logic [31:0] a, input logic [31:0] b, input acb_pkg::acb_op_t op);
    wr(acb_pkg::ACB_ACC_ADDR, a);
    wr(acb_pkg::ACB_OPND_LO_ADDR, {16'h0000, b[15:0]});
    wr(acb_pkg::ACB_OPND_HI_ADDR, {16'h0000, b[31:16]});
    wr(acb_pkg::ACB_CMD_ADDR, {26'h000_0000, op});
    exp_acc = a;
    model_op(op, b);
    rd(acb_pkg::ACB_ACC_ADDR, r);
    check("acc", r, exp_acc);
    rd(acb_pkg::ACB_FLAGS_ADDR, r);
    check("flags_reg", r, {24'h00_0000, exp_f});
    check("flags_pin", {24'h00_0000, flags}, {24'h00_0000, exp_f});
    rd(acb_pkg::ACB_CMD_ADDR, r);
    check("cmd", r, {26'h000_0000, op});
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    n_errors = 0;
    cmp_count = 0;
    hresetn = 1'b0;
    exp_acc = 32'h0000_0000;
    exp_f = acb_pkg::ACB_FLAGS_RST;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values of every register, then an unmapped place
    for (int i = 0; i < 6; i++) begin
      rd(8'(4 * i), r);
      check("reset_value", r, 32'h0000_0000);
    end
    wr(8'h14, 32'hFFFF_FFFF);
    rd(8'h14, r);
    check("unmapped", r, 32'h0000_0000);
    // Flags are read only; operand word holds 16 bits
    wr(acb_pkg::ACB_FLAGS_ADDR, 32'hFFFF_FFFF);
    rd(acb_pkg::ACB_FLAGS_ADDR, r);
    check("flags_ro", r, 32'h0000_0000);
    wr(acb_pkg::ACB_OPND_LO_ADDR, 32'hFFFF_FFFF);
    rd(acb_pkg::ACB_OPND_LO_ADDR, r);
    check("opnd_lo", r, 32'h0000_FFFF);
    // Exclusive-or, both widths
    run(32'hFFFF_1234, 32'h0000_1234, acb_pkg::ACB_OP_XOR16);
    run(32'h0000_00F0, 32'h0000_000F, acb_pkg::ACB_OP_XOR16);
    run(32'h8000_0000, 32'h0000_0001, acb_pkg::ACB_OP_XOR32);
    run(32'h3647_6A38, 32'h3647_6A38, acb_pkg::ACB_OP_XOR32);
    // Compare, both widths, each outcome
    run(32'hFFFF_0005, 32'h0000_0006, acb_pkg::ACB_OP_CMP16);
    run(32'h0000_4526, 32'h0000_4526, acb_pkg::ACB_OP_CMP16);
    run(32'h0000_8000, 32'h0000_7FFF, acb_pkg::ACB_OP_CMP16);
    run(32'h0001_0000, 32'h0000_FFFF, acb_pkg::ACB_OP_CMP32);
    run(32'h0000_0001, 32'hFFFF_FFFF, acb_pkg::ACB_OP_CMP32);
    run(32'h1234_5678, 32'h1234_5678, acb_pkg::ACB_OP_CMP32);
    // Decimal add: carries, zero, negative, bad digits
    run(32'h0000_9999, 32'h0000_0001, acb_pkg::ACB_OP_ADD16);
    run(32'hABCD_1234, 32'h0000_4321, acb_pkg::ACB_OP_ADD16);
    run(32'h9999_9999, 32'h0000_0001, acb_pkg::ACB_OP_ADD32);
    run(32'h5000_0000, 32'h4000_0000, acb_pkg::ACB_OP_ADD32);
    run(32'h0000_00A0, 32'h0000_0001, acb_pkg::ACB_OP_ADD32);
    run(32'h0000_0F00, 32'h0000_0000, acb_pkg::ACB_OP_ADD16);
    // Carry16 set here must survive the double add; bad digit in the operand
    run(32'h0000_9999, 32'h0000_0001, acb_pkg::ACB_OP_ADD16);
    run(32'h0000_0012, 32'h0000_000B, acb_pkg::ACB_OP_ADD32);
    conclude();
  end

  // Watchdog, well beyond the 138 transfers above
  initial begin
    repeat (5000) @(posedge hclk);
    n_errors++;
    conclude();
  end
endmodule

`default_nettype wire
